// file: design/pfs_pkg.sv
// Constants, types and register map of the port pin function select block.
// Assumes one 100 MHz clock, a synchronous active-low power-on reset and an
// APB master that drives the request fields as one packed struct.
// Function
// - Pin n mode field is register bits 2n+1 (upper) and 2n (lower).
// - Port D pins 4, 6: 00 alternate, 01 reserved, 10 pull-up, 11 plain in.
// - Port E, F and G selects are 16-bit read/write registers.
// - Port E power-on value is AAAA with strap high, 2AA8 with strap low.
// - Only power-on reset reloads selects; manual reset, standby, sleep keep them.
// - Port E pins 0, 7: 00 reserved, 01 output, 10 pull-up, 11 plain in.
// - Port E pins 2, 4, 5 allow alternate on 00; pins 1, 3, 6 reserve it.
// - Port F power-on value is AAAA with strap high, 00AA with strap low.
// - Port F: 00 alternate, 01 reserved, 10 pull-up, 11 plain input.
// - Port G power-on value is AAAA with strap high, A200 with strap low.
// - Port G: 00 alternate, 01 reserved, 10 pull-up, 11 plain input.
// - Pin G6 is the strap during reset, general G6 input right after release.
// - Port G pin 0 upper mode bit comes from register bit 3, not bit 1.
// - Strap low during power-on reset enters debug mode, high enters normal mode.

package pfs_pkg;

  // APB address width and register byte offsets.
  localparam int APB_AW = 8;
  localparam logic [APB_AW-1:0] OFS_PORT_D = 8'h00;
  localparam logic [APB_AW-1:0] OFS_PORT_E = 8'h04;
  localparam logic [APB_AW-1:0] OFS_PORT_F = 8'h08;
  localparam logic [APB_AW-1:0] OFS_PORT_G = 8'h0C;
  localparam logic [APB_AW-1:0] OFS_STATUS = 8'h10;

  // Status register field positions.
  localparam int STS_STRAP_BIT = 0;
  localparam int STS_DEBUG_BIT = 1;

  // Power-on values; port D is fixed, ports E, F and G follow the strap level.
  localparam logic [15:0] RST_D = 16'hAA8A;
  localparam logic [15:0] RST_STRAP_HI = 16'hAAAA;
  localparam logic [15:0] RST_E_STRAP_LO = 16'h2AA8;
  localparam logic [15:0] RST_F_STRAP_LO = 16'h00AA;
  localparam logic [15:0] RST_G_STRAP_LO = 16'hA200;

  // Per-pin legality of code 00 (alternate) and code 01 (output).
  localparam logic [7:0] D_ALT_OK = 8'hFF;
  localparam logic [7:0] D_OUT_OK = 8'hAF;
  localparam logic [7:0] E_ALT_OK = 8'h34;
  localparam logic [7:0] E_OUT_OK = 8'hFF;
  localparam logic [7:0] FG_ALT_OK = 8'hFF;
  localparam logic [7:0] FG_OUT_OK = 8'h00;

  // Register bit that carries the upper mode bit of port G pin 0.
  localparam int G0_HI_BIT = 3;

  // Mode codes of one pin.
  localparam logic [1:0] MODE_ALT = 2'h0;
  localparam logic [1:0] MODE_OUT = 2'h1;
  localparam logic [1:0] MODE_PULL = 2'h2;
  localparam logic [1:0] MODE_PLAIN = 2'h3;

  // Decoded pin controls of one 8-pin port.
  typedef struct packed {
    logic [7:0] alt_fn;
    logic [7:0] out_en;
    logic [7:0] in_en;
    logic [7:0] pull_up;
    logic [7:0] reserved;
  } pfs_port_ctl_t;

  // APB request from the master.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } pfs_apb_req_t;

  // APB answer to the master.
  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } pfs_apb_rsp_t;

endpackage : pfs_pkg

// file: design/pfs_pin_decode.sv
// Decoder from one 16-bit function select register to per-pin controls.
// Assumes the caller registers the result; this module is combinational.
`timescale 1ns/1ps

module pfs_pin_decode #(
  parameter logic [7:0] ALT_OK = 8'hFF,
  parameter logic [7:0] OUT_OK = 8'hFF,
  parameter bit G0_FIX = 1'b0
) (
  input wire logic [15:0] sel_i,
  output pfs_pkg::pfs_port_ctl_t ctl_o
);

  // Mode field of pin n, with the pin 0 upper bit taken elsewhere when asked.
  function automatic logic [1:0] pin_mode(input logic [15:0] r, input int n);
    logic hi;
    hi = r[2*n+1];
    if (G0_FIX && n == 0) begin
      hi = r[pfs_pkg::G0_HI_BIT];
    end
    return {hi, r[2*n]};
  endfunction : pin_mode

  // Turns each code into pin controls, pull-up with input enable; illegal codes show as reserved.
  always_comb begin
    ctl_o = '0;
    for (int n = 0; n < 8; n++) begin
      case (pin_mode(sel_i, n))
        pfs_pkg::MODE_ALT: begin
          ctl_o.alt_fn[n] = ALT_OK[n];
          ctl_o.reserved[n] = ~ALT_OK[n];
        end
        pfs_pkg::MODE_OUT: begin
          ctl_o.out_en[n] = OUT_OK[n];
          ctl_o.reserved[n] = ~OUT_OK[n];
        end
        pfs_pkg::MODE_PULL: begin
          ctl_o.in_en[n] = 1'b1;
          ctl_o.pull_up[n] = 1'b1;
        end
        default: begin
          ctl_o.in_en[n] = 1'b1;
        end
      endcase
    end
  end

endmodule : pfs_pin_decode

// file: design/pfs_top.sv
// Port pin function select: APB register file for ports D to G, strap
// capture during power-on reset, and registered per-pin control outputs.
// Assumes pin_g6_i is an asynchronous pin and rst_b_i is the power-on reset;
// manual reset, standby and sleep never reach this block.
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps

module pfs_top (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input pfs_pkg::pfs_apb_req_t apb_req_i,
  output pfs_pkg::pfs_apb_rsp_t apb_rsp_o,
  input wire logic pin_g6_i,
  output logic port_g6_input_o,
  output logic debug_mode_o,
  output pfs_pkg::pfs_port_ctl_t port_d_ctl_o,
  output pfs_pkg::pfs_port_ctl_t port_e_ctl_o,
  output pfs_pkg::pfs_port_ctl_t port_f_ctl_o,
  output pfs_pkg::pfs_port_ctl_t port_g_ctl_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State.

  // All flip-flops of the block.
  typedef struct packed {
    logic g6_meta;
    logic g6_sync;
    logic strap;
    logic [15:0] sel_d;
    logic [15:0] sel_e;
    logic [15:0] sel_f;
    logic [15:0] sel_g;
    pfs_pkg::pfs_apb_rsp_t rsp;
    logic g6_in;
    logic debug_mode;
    pfs_pkg::pfs_port_ctl_t ctl_d;
    pfs_pkg::pfs_port_ctl_t ctl_e;
    pfs_pkg::pfs_port_ctl_t ctl_f;
    pfs_pkg::pfs_port_ctl_t ctl_g;
  } pfs_state_t;

  pfs_state_t s;
  pfs_state_t next_s;
  pfs_pkg::pfs_port_ctl_t dec_d;
  pfs_pkg::pfs_port_ctl_t dec_e;
  pfs_pkg::pfs_port_ctl_t dec_f;
  pfs_pkg::pfs_port_ctl_t dec_g;
  logic acc;
  logic done;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Applies the two low byte lanes of a write to a 16-bit register.
  function automatic logic [15:0] wr16(input logic [15:0] old,
                                       input logic [31:0] wd,
                                       input logic [3:0] strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) begin
      r[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction : wr16

  // Says whether an address hits one of the mapped registers.
  function automatic logic is_mapped(input logic [pfs_pkg::APB_AW-1:0] a);
    return a == pfs_pkg::OFS_PORT_D || a == pfs_pkg::OFS_PORT_E ||
           a == pfs_pkg::OFS_PORT_F || a == pfs_pkg::OFS_PORT_G ||
           a == pfs_pkg::OFS_STATUS;
  endfunction : is_mapped

  ////////////////////////////////////////////////////////////////////////////
  // Pin decoders, one per port, fed from the current registers.

  // Port D: pins 4 and 6 reserve the output code.
  pfs_pin_decode #(
    .ALT_OK(pfs_pkg::D_ALT_OK),
    .OUT_OK(pfs_pkg::D_OUT_OK),
    .G0_FIX(1'b0)
  ) u_dec_d (
    .sel_i(s.sel_d),
    .ctl_o(dec_d)
  );

  // Port E: alternate only on pins 2, 4 and 5.
  pfs_pin_decode #(
    .ALT_OK(pfs_pkg::E_ALT_OK),
    .OUT_OK(pfs_pkg::E_OUT_OK),
    .G0_FIX(1'b0)
  ) u_dec_e (
    .sel_i(s.sel_e),
    .ctl_o(dec_e)
  );

  // Port F: input-only port.
  pfs_pin_decode #(
    .ALT_OK(pfs_pkg::FG_ALT_OK),
    .OUT_OK(pfs_pkg::FG_OUT_OK),
    .G0_FIX(1'b0)
  ) u_dec_f (
    .sel_i(s.sel_f),
    .ctl_o(dec_f)
  );

  // Port G: input-only port with the pin 0 upper bit moved.
  pfs_pin_decode #(
    .ALT_OK(pfs_pkg::FG_ALT_OK),
    .OUT_OK(pfs_pkg::FG_OUT_OK),
    .G0_FIX(1'b1)
  ) u_dec_g (
    .sel_i(s.sel_g),
    .ctl_o(dec_g)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  // An access phase is answered one cycle later; done marks the taking edge.
  assign acc = apb_req_i.psel & apb_req_i.penable;
  assign done = acc & s.rsp.pready;

  // Fills the next state: synchroniser, strap, registers, APB answer, outputs.
  always_comb begin
    next_s = s;

    // The pin is read only through two flops, even while in reset.
    next_s.g6_meta = pin_g6_i;
    next_s.g6_sync = s.g6_meta;

    // Pin controls follow the registers with one cycle of delay.
    next_s.ctl_d = dec_d;
    next_s.ctl_e = dec_e;
    next_s.ctl_f = dec_f;
    next_s.ctl_g = dec_g;

    if (!rst_b_i) begin
      // Power-on reset: the pin is the strap and sets the E, F and G power-on values.
      next_s.strap = s.g6_sync;
      next_s.debug_mode = ~s.g6_sync;
      next_s.g6_in = 1'b0;
      next_s.sel_d = pfs_pkg::RST_D;
      next_s.sel_e = s.g6_sync ? pfs_pkg::RST_STRAP_HI
                               : pfs_pkg::RST_E_STRAP_LO;
      next_s.sel_f = s.g6_sync ? pfs_pkg::RST_STRAP_HI
                               : pfs_pkg::RST_F_STRAP_LO;
      next_s.sel_g = s.g6_sync ? pfs_pkg::RST_STRAP_HI
                               : pfs_pkg::RST_G_STRAP_LO;
      next_s.rsp = '0;
    end else begin
      // After release the pin is an ordinary port G6 input.
      next_s.g6_in = s.g6_sync;

      // Wait state: ready rises after the first access cycle, so it is high in the second, and falls after taking.
      next_s.rsp.pready = acc & ~s.rsp.pready;
      if (acc && !s.rsp.pready) begin
        next_s.rsp.pslverr = ~is_mapped(apb_req_i.paddr);
        next_s.rsp.prdata = '0;
        if (!apb_req_i.pwrite) begin
          case (apb_req_i.paddr)
            pfs_pkg::OFS_PORT_D: begin
              next_s.rsp.prdata[15:0] = s.sel_d;
            end
            pfs_pkg::OFS_PORT_E: begin
              next_s.rsp.prdata[15:0] = s.sel_e;
            end
            pfs_pkg::OFS_PORT_F: begin
              next_s.rsp.prdata[15:0] = s.sel_f;
            end
            pfs_pkg::OFS_PORT_G: begin
              next_s.rsp.prdata[15:0] = s.sel_g;
            end
            pfs_pkg::OFS_STATUS: begin
              next_s.rsp.prdata[pfs_pkg::STS_STRAP_BIT] = s.strap;
              next_s.rsp.prdata[pfs_pkg::STS_DEBUG_BIT] = s.debug_mode;
            end
            default: begin
              next_s.rsp.prdata = '0;
            end
          endcase
        end
      end else if (!acc) begin
        next_s.rsp.pslverr = 1'b0;
        next_s.rsp.prdata = '0;
      end

      // Writes land only at the edge that sees ready; status ignores them.
      if (done && apb_req_i.pwrite) begin
        case (apb_req_i.paddr)
          pfs_pkg::OFS_PORT_D: begin
            next_s.sel_d = wr16(s.sel_d, apb_req_i.pwdata, apb_req_i.pstrb);
          end
          pfs_pkg::OFS_PORT_E: begin
            next_s.sel_e = wr16(s.sel_e, apb_req_i.pwdata,
                                apb_req_i.pstrb);
          end
          pfs_pkg::OFS_PORT_F: begin
            next_s.sel_f = wr16(s.sel_f, apb_req_i.pwdata,
                                apb_req_i.pstrb);
          end
          pfs_pkg::OFS_PORT_G: begin
            next_s.sel_g = wr16(s.sel_g, apb_req_i.pwdata,
                                apb_req_i.pstrb);
          end
          default: begin
            next_s.sel_g = s.sel_g;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  // Only the power-on reset input reloads the selects, so no other reset,
  // standby or sleep condition can disturb them.
  always_ff @(posedge clk_sys_i) begin
    s <= next_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from a flop.

  // Drives the ports from the state register.
  assign apb_rsp_o = s.rsp;
  assign port_g6_input_o = s.g6_in;
  assign debug_mode_o = s.debug_mode;
  assign port_d_ctl_o = s.ctl_d;
  assign port_e_ctl_o = s.ctl_e;
  assign port_f_ctl_o = s.ctl_f;
  assign port_g_ctl_o = s.ctl_g;

endmodule : pfs_top

// file: tb/pfs_checker.sv
// Concurrent checks on the ports of the port pin function select block.
// Assumes a bind onto pfs_top; one clock, synchronous active-low reset.
`timescale 1ns/1ps

module pfs_checker (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input pfs_pkg::pfs_apb_req_t apb_req_i,
  input pfs_pkg::pfs_apb_rsp_t apb_rsp_o,
  input wire logic pin_g6_i,
  input wire logic port_g6_input_o,
  input wire logic debug_mode_o,
  input pfs_pkg::pfs_port_ctl_t port_d_ctl_o,
  input pfs_pkg::pfs_port_ctl_t port_e_ctl_o,
  input pfs_pkg::pfs_port_ctl_t port_f_ctl_o,
  input pfs_pkg::pfs_port_ctl_t port_g_ctl_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  // A write of output codes on all port E pins is taken at this edge.
  sequence e_out_write;
    apb_req_i.psel && apb_req_i.penable && apb_rsp_o.pready && apb_req_i.pwrite &&
      apb_req_i.paddr == pfs_pkg::OFS_PORT_E && apb_req_i.pwdata[15:0] == 16'h5555 &&
      apb_req_i.pstrb[1:0] == 2'h3;
  endsequence

  //////////////////////////////////////////////////////////////////////////////
  // Bus answer shape, debug mode hold after reset, pin path and decode limits.
  ready_pulse_a: assert property (apb_rsp_o.pready |=> !apb_rsp_o.pready)
    else $error("ready held longer than one cycle");
  ready_cause_a: assert property ($rose(apb_rsp_o.pready) |->
    $past(apb_req_i.psel && apb_req_i.penable))
    else $error("ready raised without an access phase");
  mode_held_a: assert property ($past(rst_b_i) |-> $stable(debug_mode_o))
    else $error("debug mode changed outside reset");
  g6_follow_a: assert property (rst_b_i [*4] |-> port_g6_input_o == $past(pin_g6_i, 3))
    else $error("port g6 input does not follow the pin");
  e_out_decode_a: assert property (e_out_write |-> ##2 port_e_ctl_o.out_en == 8'hFF)
    else $error("port e output codes not decoded");
  e_alt_pins_a: assert property ((port_e_ctl_o.alt_fn & 8'hCB) == 8'h00)
    else $error("port e alternate function on a reserved pin");
  d_no_out_a: assert property ((port_d_ctl_o.out_en & 8'h50) == 8'h00)
    else $error("port d pin 4 or 6 driven as output");
  f_no_out_a: assert property (port_f_ctl_o.out_en == 8'h00)
    else $error("port f pin driven as output");
  g_no_out_a: assert property (port_g_ctl_o.out_en == 8'h00)
    else $error("port g pin driven as output");
  pull_in_a: assert property ((port_f_ctl_o.pull_up & ~port_f_ctl_o.in_en) == 8'h00)
    else $error("port f pull-up without input");
endmodule : pfs_checker

// file: tb/pfs_pin_model.sv
// Model of the package pin shared by port G pin 6 and the mode strap.
// Assumes the bench names the wanted level; the pad moves just after an edge.
`timescale 1ns/1ps

module pfs_pin_model (
  input wire logic clk_sys_i,
  input wire logic level_i,
  output logic pin_o
);
  // Drive the pad; the bench sets its level as reset asserts and keeps it still for the rest of reset.
  initial pin_o = 1'b1;
  always @(posedge clk_sys_i) begin
    pin_o <= level_i;
  end
endmodule : pfs_pin_model

// file: tb/tb_top.sv
// Self-checking bench for the port pin function select block.
// Assumes the APB slave answers with pready and the pin model drives G6.
`timescale 1ns/1ps

module tb_top;
  localparam logic [7:0] AD = pfs_pkg::OFS_PORT_D;
  localparam logic [7:0] AE = pfs_pkg::OFS_PORT_E;
  localparam logic [7:0] AF = pfs_pkg::OFS_PORT_F;
  localparam logic [7:0] AG = pfs_pkg::OFS_PORT_G;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic pin_lvl = 1'b1;
  logic pin_g6;
  logic g6_in;
  logic dbg;
  logic [31:0] rd;
  logic [7:0] rt_a;
  logic err;
  int fail_count = 0;
  int samples_checked = 0;
  pfs_pkg::pfs_apb_req_t req = '0;
  pfs_pkg::pfs_apb_rsp_t rsp;
  pfs_pkg::pfs_port_ctl_t d_c, e_c, f_c, g_c;

  // Free-running 100 MHz clock.
  always #5 clk_sys_i = ~clk_sys_i;

  pfs_pin_model pin_u (.clk_sys_i(clk_sys_i), .level_i(pin_lvl), .pin_o(pin_g6));
  pfs_top dut_u (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .apb_req_i(req), .apb_rsp_o(rsp),
    .pin_g6_i(pin_g6), .port_g6_input_o(g6_in), .debug_mode_o(dbg), .port_d_ctl_o(d_c),
    .port_e_ctl_o(e_c), .port_f_ctl_o(f_c), .port_g_ctl_o(g_c));

  //////////////////////////////////////////////////////////////////////////////
  // Comparison, bus and reset helpers.
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask : check

  task automatic ck8(input string n, input logic [7:0] e, input logic [7:0] g);
    check(n, {24'h0, e}, {24'h0, g});
  endtask : ck8

  // One APB transfer; the request stands until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    req <= {1'b1, 1'b0, w, a, d, 4'hF};
    @(posedge clk_sys_i);
    req.penable <= 1'b1;
    do @(posedge clk_sys_i); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask : apb

  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(n, e, rd);
  endtask : rchk

  // Write a register and wait until the decoded controls have landed.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, {16'h0, d});
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask : wr

  // Power-on reset with the strap level s, then the documented reset values.
  task automatic por(input logic s);
    @(posedge clk_sys_i);
    rst_b_i <= 1'b0;
    pin_lvl <= s;
    repeat (20) @(posedge clk_sys_i);
    // While reset is held the pin is the strap, so the port input reads low.
    check("g6_in_reset", 32'h0, {31'h0, g6_in});
    rst_b_i <= 1'b1;
    #1;
    rchk("port_d", AD, 32'h0000AA8A);
    rchk("port_e", AE, s ? 32'h0000AAAA : 32'h00002AA8);
    rchk("port_f", AF, s ? 32'h0000AAAA : 32'h000000AA);
    rchk("port_g", AG, s ? 32'h0000AAAA : 32'h0000A200);
    rchk("status", pfs_pkg::OFS_STATUS, {30'h0, ~s, s});
    check("debug_mode", {31'h0, ~s}, {31'h0, dbg});
    ck8("f_pull", s ? 8'hFF : 8'h0F, f_c.pull_up);
    ck8("g_alt", s ? 8'h00 : 8'h2F, g_c.alt_fn);
  endtask : por

  task automatic results;
    $display("Checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset values, round trips, decodes, refusal, pin path.
  initial begin
    por(1'b1);
    // Round trip on E, F and G: upper half of the write is dropped.
    for (int i = 0; i < 3; i++) begin
      rt_a = (i == 0) ? AE : ((i == 1) ? AF : AG);
      apb(1'b1, rt_a, 32'hFFFF1234);
      rchk("round_trip", rt_a, 32'h00001234);
    end
    wr(AE, 16'h5555);
    ck8("e_out", 8'hFF, e_c.out_en);
    wr(AE, 16'h0000);
    ck8("e_alt", 8'h34, e_c.alt_fn);
    ck8("e_rsv", 8'hCB, e_c.reserved);
    wr(AE, 16'hC000);
    ck8("e_plain", 8'h80, e_c.in_en & ~e_c.pull_up);
    wr(AF, 16'h5555);
    ck8("f_rsv", 8'hFF, f_c.reserved);
    wr(AG, 16'h0008);
    ck8("g_pull", 8'h03, g_c.pull_up);
    wr(AG, 16'h0002);
    ck8("g0_alt", 8'hFF, g_c.alt_fn);
    wr(AD, 16'h1100);
    ck8("d_rsv", 8'h50, d_c.reserved);
    apb(1'b0, 8'h14, 32'h0);
    check("unmapped", 32'h1, {31'h0, err});
    check("unmapped_data", 32'h0, rd);
    pin_lvl <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    #1;
    check("g6_low", 32'h0, {31'h0, g6_in});
    pin_lvl <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    #1;
    check("g6_high", 32'h1, {31'h0, g6_in});
    rchk("port_e_kept", AE, 32'h0000C000);
    por(1'b0);
    results();
  end

  // Watchdog against a hung transfer.
  initial begin
    #100us;
    fail_count++;
    results();
  end
endmodule : tb_top

bind pfs_top pfs_checker chk_u (.clk_sys_i, .rst_b_i, .apb_req_i, .apb_rsp_o, .pin_g6_i,
  .port_g6_input_o, .debug_mode_o, .port_d_ctl_o, .port_e_ctl_o, .port_f_ctl_o, .port_g_ctl_o);
